/* src/srd_bd_mem.sv */
// small descriptor table memory with registered read
module srd_bd_mem (
    // clock
    input wire logic clk_sys_i,
    input wire logic ce_i,
    // port a: software
    input wire logic a_we_i,
    input wire logic [2:0] a_addr_i,
    input wire logic [47:0] a_wdata_i,
    output logic [47:0] a_rdata_o,
    // port b: engine
    input wire logic b_we_i,
    input wire logic [2:0] b_addr_i,
    input wire logic [47:0] b_wdata_i,
    output logic [47:0] b_rdata_o
);
    logic [47:0] mem_q [0:7];

    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            if (b_we_i) begin
                mem_q[b_addr_i] <= b_wdata_i;
            end else if (a_we_i) begin
                mem_q[a_addr_i] <= a_wdata_i;
            end
            a_rdata_o <= mem_q[a_addr_i];
            b_rdata_o <= mem_q[b_addr_i];
        end
    end
endmodule

/* src/srd_pkg.sv */
// package of constants for the receive descriptor engine
// Summary of operation
// - clear empty flag once buffer filled
// - empty flag stays set while filling
// - external flag selects internal or external memory
// - after wrap descriptor return to first
// - v110 sync error on nonzero byte with msb zero
// - control bits 15-12, status bits 1 and 3 in v110, 0 and 1 in transparent
// - overrun sets descriptor overrun flag
// - transparent interrupt flag raises receive event
// - transparent carrier loss sets descriptor flag
// - length written once at buffer close
package srd_pkg;
    localparam int BD_AW = 3;
    localparam logic [2:0] BD_LAST = 3'h7;
    localparam logic [3:0] BIT_EMPTY = 4'hF;
    localparam logic [3:0] BIT_EXT = 4'hE;
    localparam logic [3:0] BIT_WRAP = 4'hD;
    localparam logic [3:0] BIT_INTR = 4'hC;
    localparam logic [3:0] BIT_SYNC = 4'h1;
    localparam logic [3:0] BIT_OVR = 4'h1;
    localparam logic [3:0] BIT_CARR = 4'h0;
    localparam logic [3:0] BIT_V110_OVR = 4'h3;
    localparam logic [15:0] STAT_MASK_V110 = 16'h000A;
    localparam logic [15:0] STAT_MASK_TRN = 16'h0003;
    localparam logic [15:0] MAX_LEN_RST = 16'h0008;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MAXLEN = 4'h1;
    localparam logic [3:0] ADDR_EVENT = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_STATE = 4'h4;
    localparam logic [3:0] ADDR_BD_CTRL = 4'h8;
    localparam logic [3:0] ADDR_BD_LEN = 4'h9;
    localparam logic [3:0] ADDR_BD_PTR = 4'hA;
    localparam logic [3:0] ADDR_BD_SEL = 4'hB;
    localparam logic [1:0] EV_RX = 2'h0;
    localparam logic [1:0] EV_CLOSE = 2'h1;
    localparam logic [1:0] EV_ERR = 2'h2;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POLL = 2'b01,
        ST_FILL = 2'b11,
        ST_CLOSE = 2'b10
    } srd_state_e;
endpackage

/* src/srd_rx.sv */
// receive descriptor engine: fills buffers and closes descriptors
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
module srd_rx (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // receiver stream
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    input wire logic rx_overrun_i,
    input wire logic carrier_n_i,
    // buffer write port
    output logic buf_we_o,
    output logic buf_ext_o,
    output logic [23:0] buf_addr_o,
    output logic [7:0] buf_data_o,
    // interrupt
    output logic irq_o
);
    logic [15:0] ctrl_q;
    logic [15:0] maxlen_q;
    logic [15:0] event_q;
    logic [15:0] mask_q;
    logic [2:0] sel_q;
    logic [2:0] cur_q;
    logic [15:0] len_q;
    logic sync_err_q;
    logic ovr_q;
    logic carr_q;
    logic carr_s1_q;
    logic carr_s2_q;
    srd_pkg::srd_state_e state_q;
    logic [15:0] stage_ctrl_q;
    logic [15:0] stage_len_q;
    logic pend_q;
    logic [2:0] pend_slot_q;
    logic [47:0] pend_data_q;
    logic [2:0] a_addr;
    logic a_we;
    logic [47:0] a_wdata;
    logic [47:0] a_rdata;
    logic b_we;
    logic [47:0] b_wdata;
    logic [47:0] b_rdata;
    logic [47:0] bd_q;
    logic enable;
    logic v110;
    logic fill_end;
    logic do_close;
    logic [15:0] status;
    logic [15:0] ev_set;
    logic fresh_q;

    assign enable = ctrl_q[0];
    assign v110 = ctrl_q[1];

    // carrier detect from pin, two stage synchroniser
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            carr_s1_q <= 1'b0;
            carr_s2_q <= 1'b0;
        end else if (ce_i) begin
            carr_s1_q <= carrier_n_i;
            carr_s2_q <= carr_s1_q;
        end
    end

    srd_bd_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .ce_i(ce_i),
        .a_we_i(a_we),
        .a_addr_i(a_addr),
        .a_wdata_i(a_wdata),
        .a_rdata_o(a_rdata),
        .b_we_i(b_we),
        .b_addr_i(cur_q),
        .b_wdata_i(b_wdata),
        .b_rdata_o(b_rdata)
    );

    // pointer word commits the staged descriptor; the commit is held
    // while the engine writes back a closed slot, so neither is lost
    assign a_we = pend_q && !b_we;
    assign a_addr = pend_q ? pend_slot_q : sel_q;
    assign a_wdata = pend_data_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            pend_slot_q <= 3'h0;
            pend_data_q <= 48'h0;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == srd_pkg::ADDR_BD_PTR) begin
                pend_q <= 1'b1;
                pend_slot_q <= sel_q;
                pend_data_q <= {stage_ctrl_q, stage_len_q, reg_wdata_i};
            end else if (!b_we) begin
                pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            stage_ctrl_q <= 16'h0000;
            stage_len_q <= 16'h0000;
            sel_q <= 3'h0;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == srd_pkg::ADDR_BD_CTRL) begin
                stage_ctrl_q <= reg_wdata_i;
            end
            if (reg_addr_i == srd_pkg::ADDR_BD_LEN) begin
                stage_len_q <= reg_wdata_i;
            end
            if (reg_addr_i == srd_pkg::ADDR_BD_SEL) begin
                sel_q <= reg_wdata_i[2:0];
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_q <= srd_pkg::CTRL_RST;
            maxlen_q <= srd_pkg::MAX_LEN_RST;
            mask_q <= 16'h0000;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == srd_pkg::ADDR_CTRL) begin
                ctrl_q <= reg_wdata_i;
            end
            if (reg_addr_i == srd_pkg::ADDR_MAXLEN) begin
                maxlen_q <= reg_wdata_i;
            end
            if (reg_addr_i == srd_pkg::ADDR_MASK) begin
                mask_q <= reg_wdata_i;
            end
        end
    end

    // buffer ends on receiver end, overrun or full length
    assign fill_end = rx_end_i || rx_overrun_i ||
        (rx_valid_i && (len_q + 16'h0001 >= maxlen_q));
    assign do_close = state_q == srd_pkg::ST_CLOSE;

    // engine state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= srd_pkg::ST_IDLE;
            cur_q <= 3'h0;
            bd_q <= 48'h0;
            fresh_q <= 1'b0;
        end else if (ce_i) begin
            // read data still show the closed slot one cycle after close
            fresh_q <= state_q != srd_pkg::ST_CLOSE;
            case (state_q)
                srd_pkg::ST_IDLE: begin
                    if (enable) begin
                        state_q <= srd_pkg::ST_POLL;
                    end
                end
                srd_pkg::ST_POLL: begin
                    bd_q <= b_rdata;
                    if (!enable) begin
                        state_q <= srd_pkg::ST_IDLE;
                    end else if (fresh_q &&
                        b_rdata[32 + srd_pkg::BIT_EMPTY]) begin
                        state_q <= srd_pkg::ST_FILL;
                    end
                end
                srd_pkg::ST_FILL: begin
                    if (fill_end) begin
                        state_q <= srd_pkg::ST_CLOSE;
                    end
                end
                srd_pkg::ST_CLOSE: begin
                    state_q <= srd_pkg::ST_POLL;
                    if (bd_q[32 + srd_pkg::BIT_WRAP] ||
                        cur_q == srd_pkg::BD_LAST) begin
                        cur_q <= 3'h0;
                    end else begin
                        cur_q <= cur_q + 3'h1;
                    end
                end
                default: begin
                    state_q <= srd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // per buffer counters and error flags
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            len_q <= 16'h0000;
            sync_err_q <= 1'b0;
            ovr_q <= 1'b0;
            carr_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q == srd_pkg::ST_POLL) begin
                len_q <= 16'h0000;
                sync_err_q <= 1'b0;
                ovr_q <= 1'b0;
                carr_q <= 1'b0;
            end else if (state_q == srd_pkg::ST_FILL) begin
                if (rx_valid_i) begin
                    len_q <= len_q + 16'h0001;
                    if (v110 && rx_data_i != 8'h00 && !rx_data_i[7]) begin
                        sync_err_q <= 1'b1;
                    end
                end
                if (rx_overrun_i) begin
                    ovr_q <= 1'b1;
                end
                if (!v110 && carr_s2_q) begin
                    carr_q <= 1'b1;
                end
            end
        end
    end

    // buffer writes target memory selected by external flag
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            buf_we_o <= 1'b0;
            buf_ext_o <= 1'b0;
            buf_addr_o <= 24'h0;
            buf_data_o <= 8'h00;
        end else if (ce_i) begin
            buf_we_o <= state_q == srd_pkg::ST_FILL && rx_valid_i;
            buf_ext_o <= bd_q[32 + srd_pkg::BIT_EXT];
            buf_addr_o <= {8'h00, bd_q[15:0]} + {8'h00, len_q};
            buf_data_o <= rx_data_i;
        end
    end

    // status layout differs per mode
    always_comb begin
        status = 16'h0000;
        if (v110) begin
            status[srd_pkg::BIT_SYNC] = sync_err_q;
            status[srd_pkg::BIT_V110_OVR] = ovr_q;
        end else begin
            status[srd_pkg::BIT_OVR] = ovr_q;
            status[srd_pkg::BIT_CARR] = carr_q;
        end
    end

    // close writes status, length and clears empty once
    assign b_we = do_close;
    always_comb begin
        b_wdata = bd_q;
        b_wdata[32 + srd_pkg::BIT_EMPTY] = 1'b0;
        if (v110) begin
            b_wdata[47:32] = (bd_q[47:32] & ~srd_pkg::STAT_MASK_V110) |
                status;
        end else begin
            b_wdata[47:32] = (bd_q[47:32] & ~srd_pkg::STAT_MASK_TRN) | status;
        end
        b_wdata[32 + srd_pkg::BIT_EMPTY] = 1'b0;
        b_wdata[31:16] = len_q;
    end

    // events, set wins over clear
    always_comb begin
        ev_set = 16'h0000;
        ev_set[srd_pkg::EV_RX] = do_close && !v110 &&
            bd_q[32 + srd_pkg::BIT_INTR];
        ev_set[srd_pkg::EV_CLOSE] = do_close;
        ev_set[srd_pkg::EV_ERR] = do_close && (ovr_q || sync_err_q || carr_q);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            event_q <= 16'h0000;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == srd_pkg::ADDR_EVENT) begin
                event_q <= (event_q & ~reg_wdata_i) | ev_set;
            end else begin
                event_q <= event_q | ev_set;
            end
        end
    end

    assign irq_o = |(event_q & mask_q);

    // read data one cycle after strobe; empty stays set while filling
    // descriptor read-back shows the selected slot, two cycles after commit
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            reg_rdata_o <= 16'h0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    srd_pkg::ADDR_CTRL: reg_rdata_o <= ctrl_q;
                    srd_pkg::ADDR_MAXLEN: reg_rdata_o <= maxlen_q;
                    srd_pkg::ADDR_EVENT: reg_rdata_o <= event_q;
                    srd_pkg::ADDR_MASK: reg_rdata_o <= mask_q;
                    srd_pkg::ADDR_STATE: begin
                        reg_rdata_o <= {11'h000, cur_q, state_q};
                    end
                    srd_pkg::ADDR_BD_SEL: begin
                        reg_rdata_o <= {13'h0000, sel_q};
                    end
                    srd_pkg::ADDR_BD_CTRL: begin
                        reg_rdata_o <= a_rdata[47:32];
                    end
                    srd_pkg::ADDR_BD_LEN: begin
                        reg_rdata_o <= a_rdata[31:16];
                    end
                    srd_pkg::ADDR_BD_PTR: begin
                        reg_rdata_o <= a_rdata[15:0];
                    end
                    default: reg_rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule

/* tb/srd_line_model.sv */
// serial line receiver model driving the byte stream
module srd_line_model (
    // clock
    input wire logic clk_sys_i,
    // stream
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    output logic rx_overrun_o,
    output logic carrier_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_end_o = 1'b0;
        rx_overrun_o = 1'b0;
        carrier_n_o = 1'b0;
    end
    task send(input logic [7:0] b);
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
    endtask
    // k[0] end pulse, k[1] overrun pulse; idle data shows inverse
    task stop(input logic [1:0] k);
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
        rx_end_o <= k[0];
        rx_overrun_o <= k[1];
        @(posedge clk_sys_i);
        rx_end_o <= 1'b0;
        rx_overrun_o <= 1'b0;
    endtask
    task drop(input logic n);
        @(posedge clk_sys_i);
        carrier_n_o <= n;
    endtask
endmodule

/* tb/srd_rx_props.sv */
// port-level checker for the receive descriptor engine
module srd_rx_props (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // stream and outputs
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic buf_we_o,
    input wire logic buf_ext_o,
    input wire logic [23:0] buf_addr_o,
    input wire logic [7:0] buf_data_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 4'h5
        |=> reg_rdata_o == 16'h0) else $error("unmapped read not zero");
    a_mask_quiet: assert property (ce_i && reg_wr_i &&
        reg_addr_i == 4'h3 && reg_wdata_i == 16'h0 |=> !irq_o)
        else $error("masked irq high");
    a_clear_quiet: assert property (ce_i && reg_wr_i &&
        reg_addr_i == 4'h2 && reg_wdata_i == 16'hFFFF && !rx_valid_i
        |=> !irq_o) else $error("irq after clear");
    a_ce_freeze: assert property (!ce_i |=> $stable(reg_rdata_o) &&
        $stable(buf_we_o) && $stable(buf_addr_o) && $stable(irq_o))
        else $error("outputs moved while clock enable low");
    a_we_cause: assert property (buf_we_o |-> $past(rx_valid_i))
        else $error("write without byte");
    a_data_copy: assert property (buf_we_o |->
        buf_data_o == $past(rx_data_i)) else $error("stored byte wrong");
    a_addr_step: assert property (buf_we_o ##1 buf_we_o |->
        buf_addr_o == $past(buf_addr_o) + 24'h1) else $error("address step");
    a_ext_steady: assert property (buf_we_o ##1 buf_we_o |->
        $stable(buf_ext_o)) else $error("memory select moved");
    a_reset_quiet: assert property ($past(rst_i) |-> !buf_we_o && !irq_o)
        else $error("output active after reset");
    c_irq: cover property ($rose(irq_o));
    c_ext: cover property (buf_we_o && buf_ext_o);
    c_int: cover property (buf_we_o && !buf_ext_o);
endmodule

bind srd_rx srd_rx_props i_srd_rx_props (.clk_sys_i, .rst_i, .ce_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_valid_i,
    .rx_data_i, .buf_we_o, .buf_ext_o, .buf_addr_o, .buf_data_o, .irq_o);

/* tb/test_serial_rx_descriptor_status.sv */
// self-checking bench for the receive descriptor engine
module test_serial_rx_descriptor_status;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic rd_seen = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic rv, re, ro, cn, we, ext, irq;
    logic [7:0] rx, bdat;
    logic [23:0] ba;
    logic [31:0] rnote;
    logic [32:0] wq[$];
    logic [31:0] rq[$];
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    srd_line_model i_srd_line_model (.clk_sys_i, .rx_valid_o(rv),
        .rx_data_o(rx), .rx_end_o(re), .rx_overrun_o(ro), .carrier_n_o(cn));
    srd_rx i_srd_rx (.clk_sys_i, .rst_i, .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .rx_valid_i(rv), .rx_data_i(rx),
        .rx_end_i(re), .rx_overrun_i(ro), .carrier_n_i(cn), .buf_we_o(we),
        .buf_ext_o(ext), .buf_addr_o(ba), .buf_data_o(bdat), .irq_o(irq));
    task final_report;
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    always @(posedge clk_sys_i) begin
        rd_seen <= rd;
        cyc++;
        if (cyc == 20000) begin
            check(1'b0, "timeout");
            final_report();
        end
    end
    always @(negedge clk_sys_i) begin
        if (we === 1'b1) begin
            if (wq.size() == 0) check(1'b0, "unexpected buffer write");
            else check({ext, ba, bdat} === wq.pop_front(), "buffer write");
        end
        if (rd_seen) begin
            rnote = rq.pop_front();
            check((rdata & rnote[31:16]) === rnote[15:0], "register read");
        end
    end
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, input logic [15:0] e,
                input logic [15:0] m);
        rq.push_back({m, e});
        @(posedge clk_sys_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask
    // pointer even, upper byte zero, reserved bits zero
    task bd(input logic [2:0] s, input logic [15:0] c, input logic [15:0] p);
        wr_reg(4'hB, {13'h0000, s});
        wr_reg(4'h8, c);
        wr_reg(4'h9, 16'h0000);
        wr_reg(4'hA, p);
    endtask
    // read back control word and length of one slot
    task bd_chk(input logic [2:0] s, input logic [15:0] c,
                input logic [15:0] n);
        wr_reg(4'hB, {13'h0000, s});
        rd_reg(4'h8, c, 16'hFFFF);
        rd_reg(4'h9, n, 16'hFFFF);
    endtask
    task put(input logic e, input logic [15:0] a, input logic [7:0] b);
        wq.push_back({e, 8'h00, a, b});
        i_srd_line_model.send(b);
    endtask
    task fill(input int n, input logic e, input logic [15:0] p,
              input logic [7:0] f);
        for (int i = 0; i < n; i++) put(e, p + 16'(i), 8'($urandom) | f);
    endtask
    task closed(input logic [15:0] ev);
        for (int i = 0; i < 50 && irq !== 1'b1; i++) @(posedge clk_sys_i);
        check(irq === 1'b1, "no interrupt");
        rd_reg(4'h2, ev, 16'hFFFF);
        wr_reg(4'h2, 16'hFFFF);
        rd_reg(4'h2, 16'h0000, 16'hFFFF);
    endtask
    initial begin
        void'($urandom(69));
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_reg(4'h1, 16'h0008, 16'hFFFF);
        rd_reg(4'h5, 16'h0000, 16'hFFFF);
        wr_reg(4'h3, 16'h0007);
        bd(3'h0, 16'hD000, 16'h0100);
        bd(3'h1, 16'hA000, 16'h0200);
        wr_reg(4'h0, 16'h0001);
        repeat (2) @(posedge clk_sys_i);
        fill(3, 1'b1, 16'h0100, 8'h00);
        i_srd_line_model.stop(2'b01);
        closed(16'h0003);
        fill(8, 1'b0, 16'h0200, 8'h00);
        i_srd_line_model.stop(2'b00);
        closed(16'h0002);
        rd_reg(4'h4, 16'h0001, 16'h001F);
        bd_chk(3'h0, 16'h5000, 16'h0003);
        bd_chk(3'h1, 16'h2000, 16'h0008);
        // writes are ignored while the clock enable is low
        @(posedge clk_sys_i);
        ce <= 1'b0;
        wr_reg(4'h3, 16'h0000);
        repeat ($urandom_range(3, 1)) @(posedge clk_sys_i);
        ce <= 1'b1;
        rd_reg(4'h3, 16'h0007, 16'hFFFF);
        bd(3'h0, 16'h8000, 16'h0300);
        bd(3'h1, 16'h8000, 16'h0400);
        bd(3'h2, 16'h8000, 16'h0500);
        bd(3'h3, 16'h8000, 16'h0600);
        wr_reg(4'h0, 16'h0003);
        put(1'b0, 16'h0300, 8'h00);
        fill(2, 1'b0, 16'h0301, 8'h80);
        i_srd_line_model.stop(2'b01);
        closed(16'h0002);
        bd_chk(3'h0, 16'h0000, 16'h0003);
        put(1'b0, 16'h0400, 8'h05);
        i_srd_line_model.stop(2'b01);
        closed(16'h0006);
        bd_chk(3'h1, 16'h0002, 16'h0001);
        rd_reg(4'h4, 16'h000B, 16'h001F);
        wr_reg(4'h0, 16'h0001);
        fill(2, 1'b0, 16'h0500, 8'h00);
        i_srd_line_model.stop(2'b10);
        closed(16'h0006);
        bd_chk(3'h2, 16'h0002, 16'h0002);
        i_srd_line_model.drop(1'b1);
        fill(4, 1'b0, 16'h0600, 8'h00);
        i_srd_line_model.stop(2'b01);
        closed(16'h0006);
        bd_chk(3'h3, 16'h0001, 16'h0004);
        i_srd_line_model.drop(1'b0);
        wr_reg(4'h3, 16'h0000);
        for (int i = 0; i < 20 && wq.size() + rq.size() > 0; i++)
            @(posedge clk_sys_i);
        check(wq.size() == 0 && rq.size() == 0, "results missing");
        final_report();
    end
endmodule
